//--- rtl/twu_pkg.sv
// package for the triple watchdog unit: register indexes, field positions,
// reset values and lookup tables. assumes nothing of its surroundings.
package twu_pkg;
	// register indexes; byte address on the bus is four times the index
	localparam logic [15:0] IDX_PERIOD = 16'h008e;
	localparam logic [15:0] IDX_MAIN_CTL = 16'h00d8;
	localparam logic [15:0] IDX_IRQ_EN = 16'h00e8;
	localparam logic [15:0] IDX_LOCK_A = 16'h00c7;
	localparam logic [15:0] IDX_LOCK_B = 16'ha0d7;
	localparam logic [15:0] IDX_B_CF = 16'ha0d8;
	localparam logic [15:0] IDX_B_LO = 16'ha0d9;
	localparam logic [15:0] IDX_B_HI = 16'ha0da;
	localparam logic [15:0] IDX_C_CF = 16'ha0db;
	localparam logic [15:0] IDX_C_LO = 16'ha0dc;
	localparam logic [15:0] IDX_C_HI = 16'ha0dd;
	// reset values
	localparam logic [7:0] PERIOD_RST = 8'hc4;
	localparam logic [7:0] MAIN_CTL_RST = 8'h02;
	localparam logic [7:0] B_CF_RST = 8'ha7;
	localparam logic [15:0] B_LIM_RST = 16'h0fff;
	localparam logic [7:0] C_CF_RST = 8'hd1;
	localparam logic [15:0] C_LIMIT = 16'h00ff;
	// field positions
	localparam int PER_B2 = 2;
	localparam int PER_B1 = 7;
	localparam int PER_B0 = 6;
	localparam int WDC_IF = 3;
	localparam int WDC_RF = 2;
	localparam int MC_REN = 1;
	localparam int WDC_RST = 0;
	localparam int IRQ_EN_MAIN = 4;
	localparam int BCF_CLR = 7;
	localparam int BCF_REN = 6;
	localparam int BCF_RF = 5;
	localparam int BCF_IEN = 4;
	localparam int BCF_CS = 1;
	localparam int BCF_IF = 0;
	localparam int CCF_CLR = 7;
	localparam int CCF_RF = 2;
	// timed-access keys, first then second
	localparam logic [7:0] KEY_FIRST = 8'haa;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	// log2 of main period per select code, entry 7 first
	localparam logic [7:0][4:0] MAIN_SHIFT = {5'd30, 5'd29, 5'd28, 5'd27,
		5'd26, 5'd23, 5'd20, 5'd17};
	// log2 of slow prescale per scaling code, entry 7 first
	localparam logic [7:0][4:0] SLOW_SHIFT = {5'd15, 5'd14, 5'd13, 5'd12,
		5'd8, 5'd8, 5'd8, 5'd8};
	typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_HALF = 2'b01, LK_OPEN = 2'b10} twu_lock_e;
endpackage

//--- rtl/twu_ta_lock.sv
// two-key write lock: key_first then key_second opens it for one write.
// assumes key and write strobes are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module twu_ta_lock
	import twu_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write strobes
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	input wire logic any_wr,
	// lock state
	output logic open
);
	typedef struct packed {
		twu_lock_e lk;
	} twu_lock_s;
	twu_lock_s st;
	twu_lock_s nx;
	always_comb
	begin
		nx = st;
		unique case (st.lk)
			LK_IDLE: if (key_wr && key_data == KEY_FIRST) nx.lk = LK_HALF;
			LK_HALF: if (any_wr) nx.lk = (key_wr && key_data == KEY_SECOND) ? LK_OPEN : LK_IDLE;
			LK_OPEN: if (any_wr) nx.lk = (key_wr && key_data == KEY_FIRST) ? LK_HALF : LK_IDLE;
			default: nx.lk = LK_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '{lk: LK_IDLE};
		else
			st <= nx;
	end
	assign open = (st.lk == LK_OPEN);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_first;
		key_wr && key_data == KEY_FIRST && st.lk == LK_IDLE;
	endsequence
	sequence s_keys;
		st.lk == LK_HALF && key_wr && key_data == KEY_SECOND;
	endsequence
	a_first_half: assert property (s_first |=> st.lk == LK_HALF) // [RULE25]
		else $error("lock not half open after first key");
	a_keys_open: assert property (s_keys |=> open) // [RULE25]
		else $error("lock not open after both keys");
	a_one_use: assert property (open && any_wr && !key_wr |=> !open) // [RULE5]
		else $error("lock stayed open after a write");
endmodule // twu_ta_lock
`default_nettype wire

//--- rtl/twu_slow_dog.sv
// 16-bit slow watchdog counter: counts ticks, pulses hit at the limit.
// assumes tick and clear are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module twu_slow_dog
	import twu_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic tick,
	input wire logic clear,
	input wire logic [WIDTH-1:0] limit,
	// state
	output logic [WIDTH-1:0] count,
	output logic hit
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic hit;
	} twu_sd_s;
	twu_sd_s st;
	twu_sd_s nx;
	always_comb
	begin
		nx = st;
		nx.hit = 1'b0;
		if (clear)
			nx.cnt = '0; // [RULE8]
		else if (tick)
		begin
			if (st.cnt == limit)
			begin
				nx.cnt = '0;
				nx.hit = 1'b1; // [RULE14]
			end
			else
				nx.cnt = st.cnt + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= nx;
	end
	assign count = st.cnt;
	assign hit = st.hit;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_hit;
		tick && !clear && count == limit;
	endsequence
	a_hit_wrap: assert property (s_hit |=> hit && count == '0) // [RULE14]
		else $error("no hit or no wrap at limit");
	a_clear_zero: assert property (clear |=> count == '0 && !hit) // [RULE18]
		else $error("clear did not zero the count");
endmodule // twu_slow_dog
`default_nettype wire

//--- rtl/twu_top.sv
// triple watchdog unit: main clock-cycle watchdog plus two slow watchdogs.
// assumes an avalon-mm master on clk and a free-running slow oscillator pin.
//
// Summary of operation
// [RULE1] main timeout always sets main irq flag; only writing zero clears it.
// [RULE2] main reset flag set on main reset; cleared by rst_n or software.
// [RULE3] main timeout resets system only when reset enable set; control resets 0x02.
// [RULE4] writing one to restart zeroes main count; restart reads zero.
// [RULE5] restart works only while timed-access lock is open.
// [RULE6] period select picks 2^17 up to 2^30 cycles; resets to 111.
// [RULE7] slow_dog_b is 16-bit on slow oscillator; gives irq, wake or reset. the unit has no wake output; a hit gives only irq or reset.
// [RULE8] writing one to slow_dog_b clear zeroes its count; self-clearing.
// [RULE9] slow_dog_b resets system only while its reset enable is one.
// [RULE10] slow_dog_b reset sets its reset flag; software zero clears it.
// [RULE11] slow_dog_b irq only while its irq enable is one.
// [RULE12] prescale select divides slow clock by 2^8, 2^12..2^15.
// [RULE13] slow_dog_b irq sets its irq flag; software zero clears it.
// [RULE14] slow_dog_b count compared with 16-bit limit; match raises irq or reset.
// [RULE15] reading slow_dog_b limit bytes returns live count bytes.
// [RULE16] slow_dog_c always runs and cannot be disabled.
// [RULE17] slow_dog_c uses the same prescale select as slow_dog_b.
// [RULE18] writing one to slow_dog_c clear zeroes its count; self-clearing.
// [RULE19] slow_dog_c reset sets its reset flag; software zero clears it.
// [RULE20] slow_dog_c low limit read-only, resets 0xff, reads count low byte.
// [RULE21] main watchdog is 30-bit; timeout gives irq or system reset.
// [RULE22] main watchdog counts only while cpu clock runs.
// [RULE23] slow_dog_c resets system when count reaches its limit.
// [RULE24] main count runs from restart until select period, then times out.
// [RULE25] software unlocks timed access right before protected writes.
`timescale 1ns/1ps
`default_nettype none
module twu_top
	import twu_pkg::*;
#(
	parameter int MAIN_SHIFT_CUT = 0,
	parameter int SLOW_SHIFT_CUT = 0
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// slow oscillator pin and cpu clock run level
	input wire logic slow_osc_clock,
	input wire logic main_dog_run,
	// events
	output logic main_dog_irq,
	output logic slow_dog_b_irq,
	output logic sys_reset_req
);
	typedef struct packed {
		logic waitreq;
		logic [7:0] rdata;
		logic s1;
		logic s2;
		logic s3;
		logic [14:0] pre;
		logic tick;
		logic [2:0] period;
		logic m_ren;
		logic m_if;
		logic m_rf;
		logic m_ien;
		logic [29:0] mcount;
		logic b_ren;
		logic b_rf;
		logic b_ien;
		logic [2:0] cs;
		logic b_if;
		logic [15:0] b_limit;
		logic c_rf;
		logic irq_m;
		logic irq_b;
		logic rst_req;
	} twu_top_s;
	twu_top_s st;
	twu_top_s nx;
	logic [15:0] idx;
	logic req;
	logic wacc;
	logic [7:0] wd;
	logic w_ck;
	logic w_wdc;
	logic w_eie;
	logic w_bcf;
	logic w_blo;
	logic w_bhi;
	logic w_ccf;
	logic open_a;
	logic open_b;
	logic restart;
	logic [4:0] msh;
	logic [29:0] m_last;
	logic m_to;
	logic [4:0] dsh;
	logic [14:0] mask;
	logic rise;
	logic b_clr;
	logic c_clr;
	logic [15:0] b_count;
	logic [15:0] c_count;
	logic b_hit;
	logic c_hit;
	logic [7:0] rd;
	assign idx = avs_address[17:2];
	assign req = avs_read | avs_write;
	assign wacc = avs_write & ~st.waitreq;
	assign wd = avs_writedata[7:0];
	assign w_ck = wacc && idx == IDX_PERIOD;
	assign w_wdc = wacc && idx == IDX_MAIN_CTL;
	assign w_eie = wacc && idx == IDX_IRQ_EN;
	assign w_bcf = wacc && idx == IDX_B_CF && open_b; // [RULE25]
	assign w_blo = wacc && idx == IDX_B_LO && open_b;
	assign w_bhi = wacc && idx == IDX_B_HI && open_b;
	assign w_ccf = wacc && idx == IDX_C_CF && open_b;
	assign restart = w_wdc & wd[WDC_RST] & open_a; // [RULE5]
	assign msh = MAIN_SHIFT[st.period] - 5'(MAIN_SHIFT_CUT); // [RULE6]
	assign m_last = 30'((31'd1 << msh) - 31'd1);
	// a count left above a newly shortened period still times out
	assign m_to = main_dog_run & (st.mcount >= m_last) & ~restart; // [RULE24]
	assign dsh = SLOW_SHIFT[st.cs] - 5'(SLOW_SHIFT_CUT); // [RULE12]
	assign mask = 15'((16'd1 << dsh) - 16'd1);
	assign rise = st.s2 & ~st.s3;
	assign b_clr = w_bcf & wd[BCF_CLR]; // [RULE8]
	assign c_clr = w_ccf & wd[CCF_CLR]; // [RULE18]
	twu_ta_lock u_lock_a (
		.clk(clk),
		.rst_n(rst_n),
		.key_wr(wacc && idx == IDX_LOCK_A),
		.key_data(wd),
		.any_wr(wacc),
		.open(open_a)
	);
	twu_ta_lock u_lock_b (
		.clk(clk),
		.rst_n(rst_n),
		.key_wr(wacc && idx == IDX_LOCK_B),
		.key_data(wd),
		.any_wr(wacc),
		.open(open_b)
	);
	twu_slow_dog #(.WIDTH(16)) u_dog_b (
		.clk(clk),
		.rst_n(rst_n),
		.tick(st.tick), // [RULE7]
		.clear(b_clr),
		.limit(st.b_limit),
		.count(b_count),
		.hit(b_hit)
	);
	twu_slow_dog #(.WIDTH(16)) u_dog_c (
		.clk(clk),
		.rst_n(rst_n),
		.tick(st.tick), // [RULE17]
		.clear(c_clr), // [RULE16]
		.limit(C_LIMIT),
		.count(c_count),
		.hit(c_hit)
	);
	always_comb
	begin
		rd = 8'h00;
		case (idx)
			IDX_PERIOD: rd = {st.period[1:0], 3'b000, st.period[2], 2'b00};
			IDX_MAIN_CTL: rd = {4'h0, st.m_if, st.m_rf, st.m_ren, 1'b0}; // [RULE4]
			IDX_IRQ_EN: rd = 8'(st.m_ien) << IRQ_EN_MAIN;
			IDX_LOCK_A: rd = 8'(open_a);
			IDX_LOCK_B: rd = 8'(open_b);
			IDX_B_CF: rd = {1'b0, st.b_ren, st.b_rf, st.b_ien, st.cs, st.b_if};
			IDX_B_LO: rd = b_count[7:0]; // [RULE15]
			IDX_B_HI: rd = b_count[15:8]; // [RULE15]
			IDX_C_CF: rd = 8'(st.c_rf) << CCF_RF;
			IDX_C_LO: rd = c_count[7:0]; // [RULE20]
			IDX_C_HI: rd = c_count[15:8];
			default: rd = 8'h00;
		endcase
	end
	always_comb
	begin
		nx = st;
		// bus answer: one wait cycle, then data with waitrequest low
		if (req && st.waitreq)
		begin
			nx.waitreq = 1'b0;
			nx.rdata = avs_read ? rd : 8'h00;
		end
		else
			nx.waitreq = 1'b1;
		// slow pin sync and prescaler
		nx.s1 = slow_osc_clock;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.pre = rise ? st.pre + 15'd1 : st.pre;
		nx.tick = rise && ((st.pre & mask) == mask); // [RULE12]
		// control fields
		if (w_ck)
			nx.period = {wd[PER_B2], wd[PER_B1], wd[PER_B0]};
		if (w_wdc)
			nx.m_ren = wd[MC_REN];
		if (w_eie)
			nx.m_ien = wd[IRQ_EN_MAIN];
		if (w_bcf)
		begin
			nx.b_ren = wd[BCF_REN];
			nx.b_ien = wd[BCF_IEN];
			nx.cs = wd[BCF_CS +: 3];
		end
		if (w_blo)
			nx.b_limit[7:0] = wd;
		if (w_bhi)
			nx.b_limit[15:8] = wd;
		// main watchdog count
		if (restart)
			nx.mcount = '0; // [RULE4]
		else if (main_dog_run) // [RULE22]
			nx.mcount = (st.mcount >= m_last) ? '0 : st.mcount + 30'd1; // [RULE21]
		// flags: hardware set wins over software clear
		nx.m_if = m_to | (st.m_if & ~(w_wdc & ~wd[WDC_IF])); // [RULE1]
		nx.m_rf = (m_to & st.m_ren) | (st.m_rf & ~(w_wdc & ~wd[WDC_RF])); // [RULE2]
		nx.b_if = (b_hit & st.b_ien) | (st.b_if & ~(w_bcf & ~wd[BCF_IF])); // [RULE13]
		nx.b_rf = (b_hit & st.b_ren) | (st.b_rf & ~(w_bcf & ~wd[BCF_RF])); // [RULE10]
		nx.c_rf = c_hit | (st.c_rf & ~(w_ccf & ~wd[CCF_RF])); // [RULE19]
		// outputs
		nx.irq_m = nx.m_if & nx.m_ien;
		nx.irq_b = nx.b_if & nx.b_ien; // [RULE11]
		nx.rst_req = (m_to & st.m_ren) | (b_hit & st.b_ren) | c_hit; // [RULE3] [RULE9] [RULE23]
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.waitreq <= 1'b1;
			st.period <= {PERIOD_RST[PER_B2], PERIOD_RST[PER_B1], PERIOD_RST[PER_B0]};
			st.m_ren <= MAIN_CTL_RST[MC_REN]; // [RULE3]
			st.b_ren <= B_CF_RST[BCF_REN];
			st.b_rf <= B_CF_RST[BCF_RF];
			st.b_ien <= B_CF_RST[BCF_IEN];
			st.cs <= B_CF_RST[BCF_CS +: 3];
			st.b_if <= B_CF_RST[BCF_IF];
			st.b_limit <= B_LIM_RST;
			st.c_rf <= C_CF_RST[CCF_RF];
		end
		else
			st <= nx;
	end
	assign avs_readdata = {24'h00_0000, st.rdata};
	assign avs_waitrequest = st.waitreq;
	assign main_dog_irq = st.irq_m;
	assign slow_dog_b_irq = st.irq_b;
	assign sys_reset_req = st.rst_req;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_bus_req;
		req && avs_waitrequest;
	endsequence
	sequence s_b_reset_hit;
		b_hit && st.b_ren;
	endsequence
	a_restart_zero: assert property (restart |=> st.mcount == '0) // [RULE4]
		else $error("restart did not zero the main count");
	a_locked_restart: assert property (w_wdc && wd[WDC_RST] && !open_a && main_dog_run // [RULE5]
		&& st.mcount < m_last |=> st.mcount == $past(st.mcount) + 30'd1)
		else $error("locked restart changed the main count");
	a_main_flag: assert property (m_to |=> st.m_if && main_dog_irq == st.m_ien) // [RULE1]
		else $error("main timeout did not set the flag");
	a_main_reset: assert property (m_to && st.m_ren |=> sys_reset_req && st.m_rf) // [RULE3]
		else $error("main timeout did not request reset");
	a_no_reset: assert property (m_to && !st.m_ren && !b_hit && !c_hit // [RULE3]
		|=> !sys_reset_req)
		else $error("reset requested while disabled");
	a_b_flag: assert property (b_hit && st.b_ien && !w_bcf |=> st.b_if && slow_dog_b_irq) // [RULE13]
		else $error("slow_dog_b irq flag not set");
	a_live_read: assert property (req && avs_waitrequest && avs_read && idx == IDX_B_LO // [RULE15]
		|=> !avs_waitrequest && avs_readdata[7:0] == $past(b_count[7:0]))
		else $error("limit read did not return count");
	a_wait_once: assert property (s_bus_req |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_b_reset: assert property (s_b_reset_hit |=> sys_reset_req && st.b_rf) // [RULE10]
		else $error("slow_dog_b hit did not reset");
	a_b_no_reset: assert property (b_hit && !st.b_ren && !m_to && !c_hit // [RULE9]
		|=> !sys_reset_req)
		else $error("slow_dog_b reset while disabled");
	a_b_irq_gate: assert property (slow_dog_b_irq == (st.b_if && st.b_ien)) // [RULE11]
		else $error("slow_dog_b irq without flag and enable");
	a_main_irq_gate: assert property (main_dog_irq == (st.m_if && st.m_ien)) // [RULE1]
		else $error("main irq without flag and enable");
	a_main_hold: assert property (!main_dog_run && !restart |=> st.mcount == $past(st.mcount)) // [RULE22]
		else $error("main count moved while stopped");
	a_b_flag_keep: assert property (st.b_if && !w_bcf |=> st.b_if) // [RULE13]
		else $error("slow_dog_b irq flag lost");
	a_c_flag_keep: assert property (st.c_rf && !w_ccf |=> st.c_rf) // [RULE19]
		else $error("slow_dog_c reset flag lost");
	a_m_flag_keep: assert property (st.m_rf && !w_wdc |=> st.m_rf) // [RULE2]
		else $error("main reset flag lost");
	a_c_clear: assert property (c_clr |=> c_count == '0) // [RULE18]
		else $error("slow_dog_c clear did not zero the count");
	a_restart_read: assert property (s_bus_req and avs_read && idx == IDX_MAIN_CTL // [RULE4]
		|=> !avs_readdata[0])
		else $error("restart bit read back as one");
	a_c_reset: assert property (c_hit |=> sys_reset_req && st.c_rf) // [RULE23]
		else $error("slow_dog_c hit did not reset");
	a_tick_rate: assert property (st.tick |-> ($past(st.pre) & mask) == mask) // [RULE12]
		else $error("prescale tick off its division");
endmodule // twu_top
`default_nettype wire

//--- testbench/twu_top_tb.sv
// self-checking bench for the triple watchdog unit top.
// assumes twu_pkg compiled first; drives the avalon-mm port and the slow pin itself.
`timescale 1ns/1ps
`default_nettype none
module twu_top_tb
	import twu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [17:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic slow_osc_clock = 1'b0;
	logic main_dog_run = 1'b0;
	logic main_dog_irq;
	logic slow_dog_b_irq;
	logic sys_reset_req;
	int n_fail = 0;
	int checks = 0;
	int n_rst = 0;
	int seed = 76927;
	int t = 0;
	int base = 0;
	logic [7:0] r = '0;
	logic [7:0] exp_q[$];
	logic [7:0] mask_q[$];

	always #2 clk = ~clk;

	twu_top #(.MAIN_SHIFT_CUT(12), .SLOW_SHIFT_CUT(6)) i_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .slow_osc_clock(slow_osc_clock),
		.main_dog_run(main_dog_run), .main_dog_irq(main_dog_irq),
		.slow_dog_b_irq(slow_dog_b_irq), .sys_reset_req(sys_reset_req)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %0t value %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// read monitor: oldest note against the answered read
	always @(posedge clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
		begin
			if (exp_q.size() == 0)
				check(8'hxx, 8'h00);
			else
			begin
				check(avs_readdata[7:0] & mask_q[0], exp_q[0]);
				void'(exp_q.pop_front());
				void'(mask_q.pop_front());
			end
		end

	always @(posedge clk)
		if (sys_reset_req === 1'b1)
			n_rst <= n_rst + 1;

	task bus_wr(input logic [15:0] idx, input logic [7:0] d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, d};
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task bus_rd(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] mask);
		exp_q.push_back(exp & mask);
		mask_q.push_back(mask);
		avs_address <= {idx, 2'b00};
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task unlock(input logic [15:0] idx);
		bus_wr(idx, KEY_FIRST);
		bus_wr(idx, KEY_SECOND);
	endtask

	task slow_edges(input int n);
		repeat (n)
		begin
			slow_osc_clock <= 1'b1;
			repeat (3) @(posedge clk);
			slow_osc_clock <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	task slow_until_rst(input int lim);
		int start;
		start = n_rst;
		t = 0;
		while (n_rst == start && t < lim)
		begin
			slow_edges(1);
			t++;
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test;
	end

	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset values and an unmapped place
		bus_rd(IDX_PERIOD, PERIOD_RST, 8'hff);
		bus_rd(IDX_MAIN_CTL, MAIN_CTL_RST, 8'hff);
		bus_rd(IDX_B_CF, 8'h27, 8'hff);
		bus_rd(IDX_C_CF, 8'h00, 8'hff);
		bus_rd(IDX_C_LO, 8'h00, 8'hff);
		bus_rd(16'h0123, 8'h00, 8'hff);
		r = 8'($random(seed));
		bus_wr(IDX_PERIOD, r & 8'hc4);
		bus_rd(IDX_PERIOD, r & 8'hc4, 8'hc4);
		// main watchdog: shortest period, reset off
		bus_wr(IDX_PERIOD, 8'h00);
		bus_wr(IDX_IRQ_EN, 8'h10);
		bus_wr(IDX_MAIN_CTL, 8'h00);
		main_dog_run <= 1'b1;
		unlock(IDX_LOCK_A);
		bus_wr(IDX_MAIN_CTL, 8'h01);
		t = 0;
		while (main_dog_irq !== 1'b1 && t < 60)
		begin
			@(posedge clk);
			t++;
		end
		check({7'h00, t >= 26 && t <= 36}, 8'h01);
		check(8'(n_rst), 8'h00);
		bus_rd(IDX_MAIN_CTL, 8'h08, 8'h0f);
		bus_wr(IDX_MAIN_CTL, 8'h00);
		bus_rd(IDX_MAIN_CTL, 8'h00, 8'h09);
		repeat (12) @(posedge clk);
		bus_wr(IDX_MAIN_CTL, 8'h01);
		repeat (18) @(posedge clk);
		check({7'h00, main_dog_irq}, 8'h01);
		// unlocked restart, then flags cleared and reset enabled in one write
		unlock(IDX_LOCK_A);
		bus_wr(IDX_MAIN_CTL, 8'h01);
		bus_wr(IDX_MAIN_CTL, 8'h02);
		base = n_rst;
		t = 0;
		while (main_dog_irq !== 1'b1 && t < 60)
		begin
			@(posedge clk);
			t++;
		end
		check({7'h00, t >= 27 && t <= 31}, 8'h01);
		repeat (2) @(posedge clk);
		check(8'(n_rst - base), 8'h01);
		main_dog_run <= 1'b0;
		bus_rd(IDX_MAIN_CTL, 8'h0e, 8'h0e);
		bus_wr(IDX_MAIN_CTL, 8'h02);
		bus_rd(IDX_MAIN_CTL, 8'h02, 8'h0f);
		base = n_rst;
		repeat (100) @(posedge clk);
		check(8'(n_rst - base), 8'h00);
		// slow watchdog b: limit 3, irq on
		unlock(IDX_LOCK_B);
		bus_wr(IDX_B_LO, 8'h03);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_B_HI, 8'h00);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_B_CF, 8'h90);
		bus_rd(IDX_B_LO, 8'h00, 8'hff);
		bus_wr(IDX_B_CF, 8'($random(seed)));
		bus_rd(IDX_B_CF, 8'h10, 8'hff);
		t = 0;
		while (slow_dog_b_irq !== 1'b1 && t < 40)
		begin
			slow_edges(1);
			t++;
		end
		check({7'h00, t >= 14 && t <= 18}, 8'h01);
		bus_rd(IDX_C_LO, 8'h04, 8'hff);
		bus_rd(IDX_B_CF, 8'h11, 8'hff);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_B_CF, 8'hc0);
		bus_rd(IDX_B_CF, 8'h40, 8'hff);
		slow_until_rst(40);
		check({7'h00, t >= 14 && t <= 18}, 8'h01);
		check({7'h00, slow_dog_b_irq}, 8'h00);
		bus_rd(IDX_B_CF, 8'h60, 8'h60);
		// slow watchdog c: fixed limit, always resets
		unlock(IDX_LOCK_B);
		bus_wr(IDX_B_CF, 8'h80);
		bus_rd(IDX_B_CF, 8'h00, 8'h60);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_C_CF, 8'h80);
		bus_rd(IDX_C_LO, 8'h00, 8'hff);
		slow_until_rst(1100);
		check({7'h00, t >= 1018 && t <= 1030}, 8'h01);
		bus_rd(IDX_C_CF, 8'h04, 8'h04);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_C_LO, 8'h5a);
		bus_rd(IDX_C_LO, 8'h00, 8'hff);
		unlock(IDX_LOCK_B);
		bus_wr(IDX_C_CF, 8'h00);
		bus_rd(IDX_C_CF, 8'h00, 8'h04);
		stop_test;
	end
endmodule // twu_top_tb
`default_nettype wire
